/* File: core/gpio_port.sv */
`default_nettype none
module gpio_port (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire gpio_pkg::io_req_t io_req,
   output logic [7:0] io_rdata_ff,
   input wire logic pullup_kill,
   input wire logic sleep_clamp,
   input wire logic [7:0] ext_int_en,
   input wire gpio_pkg::alt_ovr_t alt_ovr,
   input wire logic [7:0] pad_in,
   output logic [7:0] pad_out_ff,
   output logic [7:0] pad_oe_n_ff,
   output logic [7:0] pullup_en_ff,
   output logic [7:0] sense_ff
);
   // ============================================================
   // Register update helper
   // Full write, or single-bit set/clear that leaves other pins alone
   function automatic logic [7:0] bit_update(
      input logic [7:0] old,
      input gpio_pkg::io_req_t req,
      input logic [1:0] loc
   );
      logic [7:0] mask;
      logic [7:0] res;
      mask = 8'h01 << req.bit_idx;
      res = old;
      if (req.loc == loc) begin
         if (req.wr) begin
            res = req.wdata;
         end else if (req.bit_set) begin
            res = old | mask;
         end else if (req.bit_clr) begin
            res = old & ~mask;
         end
      end
      return res;
   endfunction : bit_update

   // ============================================================
   // Port registers
   logic [7:0] latch_ff;
   logic [7:0] dir_ff;
   logic [7:0] nxt_latch;
   logic [7:0] nxt_dir;
   logic [7:0] toggle_mask;
   logic [7:0] nxt_oe;
   logic [7:0] nxt_val;
   logic [7:0] pad_level;

   always_comb begin
      toggle_mask = gpio_pkg::ZERO_BYTE;
      if (io_req.loc == gpio_pkg::LOC_SENSE) begin
         // Sense location stores nothing; ones flip the latch
         if (io_req.wr) begin
            toggle_mask = io_req.wdata;
         end else if (io_req.bit_set) begin
            toggle_mask = 8'h01 << io_req.bit_idx;
         end
      end
   end

   always_comb begin
      nxt_latch = bit_update(latch_ff, io_req, gpio_pkg::LOC_LATCH) ^ toggle_mask;
      nxt_dir = bit_update(dir_ff, io_req, gpio_pkg::LOC_DIR);
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         latch_ff <= gpio_pkg::LATCH_RST;
      end else begin
         latch_ff <= nxt_latch;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dir_ff <= gpio_pkg::DIR_RST;
      end else begin
         dir_ff <= nxt_dir;
      end
   end

   // ============================================================
   // Pad drive
   // Built from next values so the pad moves on the same edge as the
   // register; otherwise read-back would cost an extra cycle.
   always_comb begin
      nxt_oe = (alt_ovr.dir_ovr_en & alt_ovr.dir_ovr_val)
             | (~alt_ovr.dir_ovr_en & nxt_dir);
      nxt_val = (alt_ovr.val_ovr_en & alt_ovr.val_ovr_val)
              | (~alt_ovr.val_ovr_en & nxt_latch);
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pad_oe_n_ff <= gpio_pkg::OE_N_RST;
      end else begin
         pad_oe_n_ff <= ~nxt_oe;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pad_out_ff <= gpio_pkg::ZERO_BYTE;
      end else begin
         pad_out_ff <= nxt_val;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pullup_en_ff <= gpio_pkg::ZERO_BYTE;
      end else if (pullup_kill) begin
         pullup_en_ff <= gpio_pkg::ZERO_BYTE;
      end else begin
         pullup_en_ff <= nxt_latch & ~nxt_oe;
      end
   end

   // ============================================================
   // Input path
   // Clamp sits ahead of the synchroniser so floating pads burn no power
   assign pad_level = pad_in & ~({8{sleep_clamp}} & ~ext_int_en);

   pin_sync u_pin_sync (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pad_level(pad_level),
      .sense_ff(sense_ff)
   );

   // ============================================================
   // Read port
   // Read data lands one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         io_rdata_ff <= gpio_pkg::ZERO_BYTE;
      end else if (io_req.rd) begin
         if (io_req.loc == gpio_pkg::LOC_SENSE) begin
            io_rdata_ff <= sense_ff;
         end else if (io_req.loc == gpio_pkg::LOC_DIR) begin
            io_rdata_ff <= dir_ff;
         end else if (io_req.loc == gpio_pkg::LOC_LATCH) begin
            io_rdata_ff <= latch_ff;
         end else begin
            io_rdata_ff <= gpio_pkg::ZERO_BYTE;
         end
      end
   end

   // ============================================================
   // Checks
   property p_dir_oe;
      @(posedge clk_sys) disable iff (!resetn)
      $past(alt_ovr.dir_ovr_en) == 8'h00 |-> pad_oe_n_ff == ~dir_ff;
   endproperty
   a_dir_oe: assert property (p_dir_oe)
      else $error("output enable does not follow direction");

   property p_pull_on;
      @(posedge clk_sys) disable iff (!resetn)
      ##1 (!$past(pullup_kill) && $past(alt_ovr.dir_ovr_en) == 8'h00)
         |-> pullup_en_ff == (latch_ff & ~dir_ff);
   endproperty
   a_pull_on: assert property (p_pull_on)
      else $error("pull-up not enabled for input with latch one");

   property p_pull_off;
      @(posedge clk_sys) disable iff (!resetn)
      ##1 $past(alt_ovr.dir_ovr_en) == 8'h00
         |-> (pullup_en_ff & (dir_ff | ~latch_ff)) == 8'h00;
   endproperty
   a_pull_off: assert property (p_pull_off)
      else $error("pull-up on while latch zero or output");

   property p_kill;
      @(posedge clk_sys) disable iff (!resetn)
      pullup_kill |=> pullup_en_ff == 8'h00;
   endproperty
   a_kill: assert property (p_kill)
      else $error("pull-up on while kill set");

   property p_drive;
      @(posedge clk_sys) disable iff (!resetn)
      ##1 $past(alt_ovr.val_ovr_en) == 8'h00 |-> pad_out_ff == latch_ff;
   endproperty
   a_drive: assert property (p_drive)
      else $error("pad value differs from latch");

   property p_reset_hiz;
      @(posedge clk_sys)
      !resetn |-> pad_oe_n_ff == 8'hff && pullup_en_ff == 8'h00;
   endproperty
   a_reset_hiz: assert property (p_reset_hiz)
      else $error("pad not tri-stated in reset");

   property p_toggle;
      @(posedge clk_sys) disable iff (!resetn)
      (io_req.wr && io_req.loc == gpio_pkg::LOC_SENSE)
         |=> latch_ff == ($past(latch_ff) ^ $past(io_req.wdata));
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("sense write did not toggle latch");

   property p_read_sense;
      @(posedge clk_sys) disable iff (!resetn)
      (io_req.rd && io_req.loc == gpio_pkg::LOC_SENSE)
         |=> io_rdata_ff == $past(sense_ff);
   endproperty
   a_read_sense: assert property (p_read_sense)
      else $error("sense read returned wrong data");

   property p_sw_sense;
      @(posedge clk_sys) disable iff (!resetn)
      ($past(alt_ovr.val_ovr_en) == 8'h00 && pad_oe_n_ff == 8'h00 && !sleep_clamp
         && $changed(pad_out_ff)) |=> sense_ff == $past(pad_out_ff);
   endproperty
   a_sw_sense: assert property (p_sw_sense)
      else $error("software level not sensed after one cycle");

   property p_bit_set;
      @(posedge clk_sys) disable iff (!resetn)
      (io_req.bit_set && !io_req.wr && io_req.loc == gpio_pkg::LOC_DIR)
         |=> dir_ff == ($past(dir_ff) | (8'h01 << $past(io_req.bit_idx)));
   endproperty
   a_bit_set: assert property (p_bit_set)
      else $error("bit set disturbed other direction bits");

   property p_clamp;
      @(posedge clk_sys) disable iff (!resetn)
      (sleep_clamp && ext_int_en == 8'h00) [*2] |=> sense_ff == 8'h00;
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("clamped input not sensed low");

   property p_bit_clr;
      @(posedge clk_sys) disable iff (!resetn)
      (io_req.bit_clr && !io_req.wr && !io_req.bit_set && io_req.loc == gpio_pkg::LOC_DIR)
         |=> dir_ff == ($past(dir_ff) & ~(8'h01 << $past(io_req.bit_idx)));
   endproperty
   a_bit_clr: assert property (p_bit_clr)
      else $error("bit clear disturbed other direction bits");

   property p_sense_clr;
      @(posedge clk_sys) disable iff (!resetn)
      (io_req.bit_clr && !io_req.wr && !io_req.bit_set && io_req.loc == gpio_pkg::LOC_SENSE)
         |=> latch_ff == $past(latch_ff);
   endproperty
   a_sense_clr: assert property (p_sense_clr)
      else $error("bit clear on sense location changed the latch");

   property p_rd_unmapped;
      @(posedge clk_sys) disable iff (!resetn)
      (io_req.rd && io_req.loc == 2'h3) |=> io_rdata_ff == 8'h00;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped)
      else $error("unmapped location read not zero");

   // Pins left alone by a direction override keep plain port behaviour; a value override drives its own pins
   property p_ovr_dir;
      @(posedge clk_sys) disable iff (!resetn)
      $past(alt_ovr.dir_ovr_en) != 8'h00
         |-> (~pad_oe_n_ff & ~$past(alt_ovr.dir_ovr_en))
            == (dir_ff & ~$past(alt_ovr.dir_ovr_en));
   endproperty
   a_ovr_dir: assert property (p_ovr_dir)
      else $error("direction override leaked to other pins");

   property p_ovr_val;
      @(posedge clk_sys) disable iff (!resetn)
      $past(alt_ovr.val_ovr_en) != 8'h00
         |-> (pad_out_ff & $past(alt_ovr.val_ovr_en))
            == ($past(alt_ovr.val_ovr_val) & $past(alt_ovr.val_ovr_en));
   endproperty
   a_ovr_val: assert property (p_ovr_val)
      else $error("value override not applied to its pins");
endmodule : gpio_port
`default_nettype wire

/* File: core/gpio_pkg.sv */
`default_nettype none
// ============================================================
// Shared constants and carriers
package gpio_pkg;
   localparam int PORT_W = 8;
   // I/O location select within the port
   localparam logic [1:0] LOC_SENSE = 2'h0;
   localparam logic [1:0] LOC_DIR = 2'h1;
   localparam logic [1:0] LOC_LATCH = 2'h2;
   // Values after reset
   localparam logic [7:0] LATCH_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'h00;
   localparam logic [7:0] OE_N_RST = 8'hff;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // Input synchroniser delay for a software-driven level, cycles
   localparam int SW_SENSE_CYC = 1;

   typedef struct packed {
      logic [1:0] loc;
      logic wr;
      logic rd;
      logic bit_set;
      logic bit_clr;
      logic [2:0] bit_idx;
      logic [7:0] wdata;
   } io_req_t;

   typedef struct packed {
      logic [7:0] dir_ovr_en;
      logic [7:0] dir_ovr_val;
      logic [7:0] val_ovr_en;
      logic [7:0] val_ovr_val;
   } alt_ovr_t;
endpackage : gpio_pkg
`default_nettype wire

/* File: core/pin_sync.sv */
`default_nettype none
// ============================================================
// Pad input synchroniser: high-phase latch then rising-edge flop
module pin_sync (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] pad_level,
   output logic [7:0] sense_ff
);
   logic [7:0] sync_lat;

   // Transparent while clock high, holds while low
   always_latch begin
      if (!resetn) begin
         sync_lat <= gpio_pkg::ZERO_BYTE;
      end else if (clk_sys) begin
         sync_lat <= pad_level;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sense_ff <= gpio_pkg::ZERO_BYTE;
      end else begin
         sense_ff <= sync_lat;
      end
   end
endmodule : pin_sync
`default_nettype wire

/* File: verification/pad_board.sv */
`default_nettype none
// ============================================================
// Board side of the pads: drivers, pull-ups, floating lines
module pad_board (
   input wire logic clk_sys,
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe_n,
   input wire logic [7:0] pullup_en,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] pad_level
);
   timeunit 1ns;
   timeprecision 1ns;
   // Floating pins wander, so a stale level never passes for a real one
   logic [7:0] float_ff = 8'h0055;
   always @(posedge clk_sys) begin
      float_ff <= ~float_ff;
   end
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         if (!pad_oe_n[n]) pad_level[n] = pad_out[n];
         else if (ext_en[n]) pad_level[n] = ext_val[n];
         else if (pullup_en[n]) pad_level[n] = 1'b1;
         else pad_level[n] = float_ff[n];
      end
   end
endmodule : pad_board
`default_nettype wire

/* File: verification/gpio_port_tb_top.sv */
`default_nettype none
// ============================================================
// Self-checking bench for one port
module gpio_port_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic resetn = 1'b1;
   gpio_pkg::io_req_t req = '0;
   logic pullup_kill = 1'b0;
   logic sleep_clamp = 1'b0;
   logic [7:0] ext_int_en = 8'h00;
   gpio_pkg::alt_ovr_t alt_ovr = '0;
   logic [7:0] ext_en = 8'h0000;
   logic [7:0] ext_val = 8'h0000;
   logic [7:0] pad_level, rdata, pad_out, oe_n, pu_en, sense;
   int n_mismatch = 0;
   int checked = 0;
   always #5 clk_sys = ~clk_sys;
   gpio_port dut (.clk_sys(clk_sys), .resetn(resetn), .io_req(req), .io_rdata_ff(rdata),
      .pullup_kill(pullup_kill), .sleep_clamp(sleep_clamp), .ext_int_en(ext_int_en),
      .alt_ovr(alt_ovr), .pad_in(pad_level), .pad_out_ff(pad_out), .pad_oe_n_ff(oe_n),
      .pullup_en_ff(pu_en), .sense_ff(sense));
   pad_board board (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe_n(oe_n),
      .pullup_en(pu_en), .ext_en(ext_en), .ext_val(ext_val), .pad_level(pad_level));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One request for one edge; it stands until the next op or idle, never set twice a step
   task op(input logic [1:0] l, input logic w, r, s, c, input logic [2:0] i,
           input logic [7:0] d);
      req = '{loc: l, wr: w, rd: r, bit_set: s, bit_clr: c, bit_idx: i, wdata: d};
      @(posedge clk_sys);
      #1;
   endtask : op
   task idle;
      req = '0;
      @(posedge clk_sys);
      #1;
   endtask : idle
   task wr(input logic [1:0] l, input logic [7:0] d);
      op(l, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, d);
   endtask : wr
   task rd(input logic [1:0] l, input logic [7:0] exp);
      op(l, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 8'h0000);
      chk(rdata, exp);
   endtask : rd
   task t_reset;
      chk(oe_n, gpio_pkg::OE_N_RST);
      chk(pu_en, 8'h0000);
      rd(gpio_pkg::LOC_LATCH, gpio_pkg::LATCH_RST);
      rd(gpio_pkg::LOC_DIR, gpio_pkg::DIR_RST);
      $display("t_reset done");
   endtask : t_reset
   task t_cfg;
      ext_en = 8'h00fe;
      ext_val = 8'h0000;
      wr(gpio_pkg::LOC_LATCH, 8'h0001);
      chk(pu_en, 8'h0001);
      chk(oe_n, 8'h00ff);
      wr(gpio_pkg::LOC_DIR, 8'h0001);
      chk(oe_n, 8'h00fe);
      chk(pu_en, 8'h0000);
      chk(pad_out & 8'h0001, 8'h0001);
      wr(gpio_pkg::LOC_LATCH, 8'h0000);
      chk(pad_out & 8'h0001, 8'h0000);
      chk(sense & 8'h0001, 8'h0001);
      idle();
      chk(sense & 8'h0001, 8'h0000);
      rd(gpio_pkg::LOC_SENSE, 8'h0000);
      rd(gpio_pkg::LOC_DIR, 8'h0001);
      wr(2'h3, 8'h00ff);
      rd(2'h3, 8'h0000);
      rd(gpio_pkg::LOC_LATCH, 8'h0000);
      $display("t_cfg done");
   endtask : t_cfg
   task t_kill;
      wr(gpio_pkg::LOC_DIR, 8'h0000);
      wr(gpio_pkg::LOC_LATCH, 8'h00ff);
      chk(pu_en, 8'h00ff);
      pullup_kill = 1'b1;
      idle();
      chk(pu_en, 8'h0000);
      pullup_kill = 1'b0;
      $display("t_kill done");
   endtask : t_kill
   task t_toggle;
      wr(gpio_pkg::LOC_SENSE, 8'h000f);
      rd(gpio_pkg::LOC_LATCH, 8'h00f0);
      op(gpio_pkg::LOC_SENSE, 1'b0, 1'b0, 1'b1, 1'b0, 3'h7, 8'h0000);
      rd(gpio_pkg::LOC_LATCH, 8'h0070);
      op(gpio_pkg::LOC_DIR, 1'b0, 1'b0, 1'b1, 1'b0, 3'h2, 8'h0000);
      op(gpio_pkg::LOC_DIR, 1'b0, 1'b0, 1'b1, 1'b0, 3'h3, 8'h0000);
      op(gpio_pkg::LOC_DIR, 1'b0, 1'b0, 1'b0, 1'b1, 3'h2, 8'h0000);
      rd(gpio_pkg::LOC_DIR, 8'h0008);
      op(gpio_pkg::LOC_SENSE, 1'b0, 1'b0, 1'b0, 1'b1, 3'h6, 8'h0000);
      rd(gpio_pkg::LOC_LATCH, 8'h0070);
      $display("t_toggle done");
   endtask : t_toggle
   task t_ext;
      wr(gpio_pkg::LOC_DIR, 8'h0000);
      ext_en = 8'h00ff;
      ext_val = 8'h00a5;
      idle();
      chk(sense, 8'h00a5);
      rd(gpio_pkg::LOC_SENSE, 8'h00a5);
      $display("t_ext done");
   endtask : t_ext
   task t_async;
      ext_en = 8'h0000;
      wr(gpio_pkg::LOC_DIR, 8'h00ff);
      chk(oe_n, 8'h0000);
      resetn = 1'b0;
      #1;
      chk(oe_n, gpio_pkg::OE_N_RST);
      @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      rd(gpio_pkg::LOC_DIR, gpio_pkg::DIR_RST);
      $display("t_async done");
   endtask : t_async
   task t_readback;
      wr(gpio_pkg::LOC_DIR, 8'h00ff);
      wr(gpio_pkg::LOC_LATCH, 8'h003c);
      chk(pad_out, 8'h003c);
      chk(pu_en, 8'h0000);
      rd(gpio_pkg::LOC_SENSE, 8'h0000);
      chk(sense, 8'h003c);
      rd(gpio_pkg::LOC_SENSE, 8'h003c);
      $display("t_readback done");
   endtask : t_readback
   task t_ovr_clamp;
      alt_ovr = '{dir_ovr_en: 8'h01, dir_ovr_val: 8'h00,
                  val_ovr_en: 8'h80, val_ovr_val: 8'h80};
      idle();
      chk(oe_n, 8'h0001);
      chk(pad_out, 8'h00bc);
      alt_ovr = '0;
      idle();
      chk(oe_n, 8'h0000);
      chk(pad_out, 8'h003c);
      wr(gpio_pkg::LOC_DIR, 8'h0000);
      ext_en = 8'h00ff;
      ext_val = 8'h00ff;
      sleep_clamp = 1'b1;
      ext_int_en = 8'h000f;
      idle();
      chk(sense, 8'h000f);
      ext_int_en = 8'h0000;
      idle();
      idle();
      chk(sense, 8'h0000);
      sleep_clamp = 1'b0;
      idle();
      chk(sense, 8'h00ff);
      ext_en = 8'h0000;
      $display("t_ovr_clamp done");
   endtask : t_ovr_clamp
   task stop_test;
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test
   // Tests take well under a microsecond; the margin covers slow runs
   initial begin
      #20000;
      n_mismatch++;
      stop_test();
   end
   initial begin
      #1;
      resetn = 1'b0;
      repeat (12) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      t_reset();
      t_cfg();
      t_kill();
      t_toggle();
      t_ext();
      t_async();
      t_readback();
      t_ovr_clamp();
      stop_test();
   end
endmodule : gpio_port_tb_top
`default_nettype wire
